// *** cbm_pkg.sv ***
package cbm_pkg;
	// Line geometry
	localparam int LINE_SH = 7;
	localparam int BIG_LB = 16 - LINE_SH;
	localparam int SMALL_LB = 12 - LINE_SH;
	localparam int ALIAS_LINES = 8;
	localparam int STREAMS = 8;
	localparam int PER_THREAD = 4;

	// Operation codes from the load/store pipe
	localparam logic [2:0] OP_ICBI = 3'h0;
	localparam logic [2:0] OP_TOUCH = 3'h1;
	localparam logic [2:0] OP_TOUCH_ST = 3'h2;
	localparam logic [2:0] OP_ZERO = 3'h3;
	localparam logic [2:0] OP_FLUSH = 3'h4;
	localparam logic [2:0] OP_STORE = 3'h5;
	localparam logic [2:0] OP_VSTREAM = 3'h6;

	// Touch hints and stop codes
	localparam logic [3:0] HINT_PLAIN = 4'h0;
	localparam logic [3:0] HINT_STREAM = 4'h8;
	localparam logic [3:0] HINT_STREAM_EXT = 4'ha;
	localparam logic [1:0] STOP_ALL = 2'h3;
	localparam logic [1:0] STOP_ONE = 2'h2;

	// Store queue request kinds
	localparam logic [1:0] SQ_ZERO = 2'h0;
	localparam logic [1:0] SQ_FLUSH = 2'h1;
	localparam logic [1:0] SQ_STORE = 2'h2;

	// Register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int CTRL_FGL_B = 0;
	localparam int CTRL_ITD_B = 1;
	localparam int CTRL_STL_B = 2;
	localparam int CTRL_WAY_LO = 4;
	localparam int STAT_BUSY_B = 8;
	localparam logic CTRL_BIT_RST = 1'h0;
	localparam logic [3:0] CTRL_WAY_RST = 4'hf;

	typedef enum logic [1:0] {IC_IDLE, IC_SCAN, IC_KILL} cbm_ic_state_t;
endpackage

// *** cbm_top.sv ***
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// Contract
// - Instruction invalidate works on 128-byte lines; instruction cache is never snooped.
// - Instruction invalidate uses data translation; a fault becomes a data storage exception.
// - Invalidate probes eight alias lines: pass one builds a vector, pass two invalidates.
// - Each local invalidate is broadcast with its line; invalidates from peers are performed; one is held, and a second before it starts replaces it.
// - Touch with translation enabled that faults is cancelled with no exception.
// - Touch TLB miss in hardware lookup mode reloads TLB and sets reference bit.
// - Touch cancelled on protection, inhibited, software lookup mode or guarded page.
// - Touch on L1 miss asks second level; L1 filled only for hint 0000.
// - Touch-for-store equals touch with hint 0000; touches act on 128-byte lines.
// - Eight prefetch streams, four owned by each of two threads.
// - Hints 0000, 1000, 1010; other 0x as 0000, other 1x ignored.
// - Active streams served round-robin, one line request each, lowest load priority.
// - Forced guarded loads make touches no-ops; a bit disables indexed touches.
// - Demand load hitting a pending prefetch drops it; the stream stays active.
// - Hint 1010 go 0: stop 11 ends thread streams, stop 10 ends one.
// - Stream touch naming an active stream restarts it with the new state.
// - Streams end at page boundary, at most every 64 KB; hint 1010 streams also end at unit count.
// - Real mode or disabled thread ends its streams; TLB invalidate ends all.
// - Block zero drops L1 copy, then zeroes 128 bytes in order through store queue.
// - Block zero clears even bad lines; inhibited or no L1 ways gives alignment interrupt.
// - Block flush writes back and invalidates everywhere; block store keeps copies.
// - Legacy vector stream touch and stop operations are no-ops.
module cbm_top #(
	parameter int RA_W = 42,
	parameter int UC_W = 10
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Operation from the load/store pipe
	input wire logic op_valid,
	input wire logic [2:0] op_code,
	input wire logic op_thread,
	input wire logic [RA_W-1:0] op_ra,
	input wire logic op_indexed,
	input wire logic [3:0] touch_hint,
	input wire logic [1:0] op_stream_id,
	input wire logic op_go,
	input wire logic [1:0] op_stop,
	input wire logic [UC_W-1:0] stream_unit_count,
	input wire logic op_page_4k,
	input wire logic l1d_hit,
	output logic op_busy,
	// Result of the data translation array
	input wire logic xl_fault,
	input wire logic xl_tlb_miss,
	input wire logic xl_pte_found,
	input wire logic xl_prot_fail,
	input wire logic xl_cache_inhibit,
	input wire logic xl_guarded,
	// Thread state
	input wire logic [1:0] data_translate_enable,
	input wire logic [1:0] thread_enable,
	input wire logic tlbie_event,
	// Exceptions and TLB
	output logic dsi_exc,
	output logic align_int,
	output logic tlb_reload,
	output logic [RA_W-8:0] out_line,
	// Instruction cache
	output logic ic_probe,
	output logic ic_inval,
	output logic [2:0] ic_line_idx,
	output logic [RA_W-8:0] ic_line,
	input wire logic ic_probe_hit,
	// Invalidate broadcast
	output logic bc_out_valid,
	output logic [RA_W-8:0] bc_out_line,
	input wire logic bc_in_valid,
	input wire logic [RA_W-8:0] bc_in_line,
	// Data caches and store queue
	output logic l1d_inval,
	output logic l2_touch_req,
	output logic l2_touch_l1_fill,
	output logic sq_req,
	output logic [1:0] sq_kind,
	// Prefetch to second level
	output logic pf_req,
	output logic [2:0] pf_stream,
	output logic [RA_W-8:0] pf_line,
	input wire logic pf_ready,
	input wire logic pf_drop,
	input wire logic [2:0] pf_drop_stream
);
	localparam int LA_W = RA_W - cbm_pkg::LINE_SH;
	logic fgl_reg, itd_reg, stl_reg;
	logic [3:0] way_reg;
	cbm_pkg::cbm_ic_state_t ic_state;
	logic [7:0] ic_vec;
	logic bc_pend;
	logic [LA_W-1:0] bc_pend_line;
	logic zero_pend;
	logic [2:0] rr_reg;
	logic [cbm_pkg::STREAMS-1:0] s_act;
	logic [cbm_pkg::STREAMS-1:0] s_thr;
	logic [cbm_pkg::STREAMS-1:0] s_lim;
	logic [cbm_pkg::STREAMS-1:0] s_p4k;
	logic [LA_W-1:0] s_la [cbm_pkg::STREAMS];
	logic [UC_W-1:0] s_cnt [cbm_pkg::STREAMS];
	////////////////////////////////////////////////////////////////////////
	// Register port
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fgl_reg <= cbm_pkg::CTRL_BIT_RST;
			itd_reg <= cbm_pkg::CTRL_BIT_RST;
			stl_reg <= cbm_pkg::CTRL_BIT_RST;
			way_reg <= cbm_pkg::CTRL_WAY_RST;
		end else if (reg_wr && reg_addr == cbm_pkg::REG_CTRL) begin
			fgl_reg <= reg_wdata[cbm_pkg::CTRL_FGL_B];
			itd_reg <= reg_wdata[cbm_pkg::CTRL_ITD_B];
			stl_reg <= reg_wdata[cbm_pkg::CTRL_STL_B];
			way_reg <= reg_wdata[cbm_pkg::CTRL_WAY_LO +: 4];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd && reg_addr == cbm_pkg::REG_CTRL) begin
			reg_rdata <= {24'h0, way_reg, 1'b0, stl_reg, itd_reg, fgl_reg};
		end else if (reg_rd && reg_addr == cbm_pkg::REG_STAT) begin
			reg_rdata <= {23'h0, ic_state != cbm_pkg::IC_IDLE, s_act};
		end else begin
			reg_rdata <= 32'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Operation decode
	logic acc, is_touch, t_nop, t_on, xl_bad, is_stop, stop_all, stop_one;
	logic s_start, t_fetch, ic_local, ic_go, zero_ok, sq_ok;
	logic [3:0] hint_eff;
	logic [2:0] s_idx;
	logic [LA_W-1:0] op_line;
	always_comb begin
		acc = op_valid && !op_busy;
		op_line = op_ra[RA_W-1:cbm_pkg::LINE_SH];
		is_touch = acc && (op_code == cbm_pkg::OP_TOUCH || op_code == cbm_pkg::OP_TOUCH_ST);
		// Touch-for-store and all other 0xxx hints fold to the plain form
		hint_eff = (op_code == cbm_pkg::OP_TOUCH_ST || !touch_hint[3]) ?
			cbm_pkg::HINT_PLAIN : touch_hint;
		t_nop = fgl_reg || (op_indexed && itd_reg) || (hint_eff[3] &&
			hint_eff != cbm_pkg::HINT_STREAM && hint_eff != cbm_pkg::HINT_STREAM_EXT);
		t_on = is_touch && !t_nop;
		xl_bad = (data_translate_enable[op_thread] && xl_fault) ||
			xl_prot_fail || xl_cache_inhibit || xl_guarded || stl_reg ||
			(xl_tlb_miss && !xl_pte_found);
		is_stop = hint_eff == cbm_pkg::HINT_STREAM_EXT && !op_go;
		stop_all = t_on && is_stop && op_stop == cbm_pkg::STOP_ALL;
		stop_one = t_on && is_stop && op_stop == cbm_pkg::STOP_ONE;
		s_start = t_on && !is_stop && hint_eff != cbm_pkg::HINT_PLAIN && !xl_bad;
		t_fetch = t_on && !is_stop && !xl_bad;
		s_idx = {op_thread, op_stream_id};
		ic_local = acc && op_code == cbm_pkg::OP_ICBI && !xl_fault;
		ic_go = ic_state == cbm_pkg::IC_IDLE && (ic_local || bc_pend);
		zero_ok = acc && op_code == cbm_pkg::OP_ZERO && !xl_fault &&
			!xl_cache_inhibit && way_reg != 4'h0;
		sq_ok = acc && !xl_fault && (op_code == cbm_pkg::OP_FLUSH || op_code == cbm_pkg::OP_STORE);
	end
	////////////////////////////////////////////////////////////////////////
	// Pulses for translation, touch, zero, flush and store
	// Legacy vector stream codes fall through every branch and do nothing
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			dsi_exc <= 1'b0;
			align_int <= 1'b0;
			tlb_reload <= 1'b0;
			l2_touch_req <= 1'b0;
			l2_touch_l1_fill <= 1'b0;
			l1d_inval <= 1'b0;
			zero_pend <= 1'b0;
			sq_req <= 1'b0;
			sq_kind <= cbm_pkg::SQ_ZERO;
			out_line <= '0;
		end else begin
			dsi_exc <= acc && xl_fault && (op_code == cbm_pkg::OP_ICBI ||
				op_code == cbm_pkg::OP_ZERO || op_code == cbm_pkg::OP_FLUSH ||
				op_code == cbm_pkg::OP_STORE);
			align_int <= acc && op_code == cbm_pkg::OP_ZERO && !xl_fault &&
				(xl_cache_inhibit || way_reg == 4'h0);
			tlb_reload <= t_fetch && xl_tlb_miss;
			l2_touch_req <= t_fetch && !l1d_hit;
			l2_touch_l1_fill <= hint_eff == cbm_pkg::HINT_PLAIN;
			// Zero ignores line errors; the second level overwrites all of it
			l1d_inval <= zero_ok && l1d_hit;
			zero_pend <= zero_ok;
			sq_req <= zero_pend || sq_ok;
			if (zero_pend) begin
				sq_kind <= cbm_pkg::SQ_ZERO;
			end else if (op_code == cbm_pkg::OP_FLUSH) begin
				sq_kind <= cbm_pkg::SQ_FLUSH;
			end else begin
				sq_kind <= cbm_pkg::SQ_STORE;
			end
			if (acc) begin
				out_line <= op_line;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			op_busy <= 1'b0;
		end else begin
			op_busy <= zero_ok || ic_local || bc_in_valid || bc_pend ||
				(ic_state != cbm_pkg::IC_IDLE &&
				!(ic_state == cbm_pkg::IC_KILL && ic_line_idx == 3'h7));
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Instruction cache invalidate
	// One peer invalidate is held; a second before it starts replaces it, so the first is lost
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bc_pend <= 1'b0;
			bc_pend_line <= '0;
			bc_out_valid <= 1'b0;
			bc_out_line <= '0;
		end else begin
			if (bc_in_valid) begin
				bc_pend <= 1'b1;
				bc_pend_line <= bc_in_line;
			end else if (ic_go && !ic_local) begin
				bc_pend <= 1'b0;
			end
			bc_out_valid <= ic_local;
			if (ic_local) begin
				bc_out_line <= op_line;
			end
		end
	end
	// Aliases mean the line may sit at any of eight places; no snoop keeps it coherent
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ic_state <= cbm_pkg::IC_IDLE;
			ic_vec <= 8'h0;
			ic_probe <= 1'b0;
			ic_inval <= 1'b0;
			ic_line_idx <= 3'h0;
			ic_line <= '0;
		end else begin
			case (ic_state)
				cbm_pkg::IC_IDLE: begin
					if (ic_go) begin
						ic_state <= cbm_pkg::IC_SCAN;
						ic_line_idx <= 3'h0;
						ic_probe <= 1'b1;
						ic_line <= ic_local ? op_line : bc_pend_line;
					end
				end
				cbm_pkg::IC_SCAN: begin
					ic_vec[ic_line_idx] <= ic_probe_hit;
					if (ic_line_idx == 3'h7) begin
						ic_state <= cbm_pkg::IC_KILL;
						ic_line_idx <= 3'h0;
						ic_probe <= 1'b0;
						ic_inval <= ic_vec[0];
					end else begin
						ic_line_idx <= ic_line_idx + 3'h1;
					end
				end
				cbm_pkg::IC_KILL: begin
					if (ic_line_idx == 3'h7) begin
						ic_state <= cbm_pkg::IC_IDLE;
						ic_inval <= 1'b0;
					end else begin
						ic_line_idx <= ic_line_idx + 3'h1;
						ic_inval <= ic_vec[ic_line_idx + 3'h1];
					end
				end
				default: begin
					ic_state <= cbm_pkg::IC_IDLE;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Stream entries
	genvar e;
	generate
		for (e = 0; e < cbm_pkg::STREAMS; e++) begin : g_stream
			logic kill, adv, bnd;
			assign kill = tlbie_event || !data_translate_enable[s_thr[e]] ||
				!thread_enable[s_thr[e]] || (stop_all && op_thread == s_thr[e]) ||
				(stop_one && s_idx == 3'(e));
			// Dropped prefetches still move the stream on, the demand load has the line
			assign adv = pf_req && pf_stream == 3'(e) &&
				(pf_ready || (pf_drop && pf_drop_stream == 3'(e)));
			assign bnd = s_p4k[e] ? &s_la[e][cbm_pkg::SMALL_LB-1:0] :
				&s_la[e][cbm_pkg::BIG_LB-1:0];
			always_ff @(posedge clk_sys) begin
				if (!rstn) begin
					s_act[e] <= 1'b0;
					s_thr[e] <= 1'b0;
					s_lim[e] <= 1'b0;
					s_p4k[e] <= 1'b0;
					s_la[e] <= '0;
					s_cnt[e] <= '0;
				end else if (kill) begin
					s_act[e] <= 1'b0;
				end else if (s_start && s_idx == 3'(e)) begin
					s_act[e] <= 1'b1;
					s_thr[e] <= op_thread;
					s_lim[e] <= hint_eff == cbm_pkg::HINT_STREAM_EXT;
					s_p4k[e] <= op_page_4k;
					s_la[e] <= op_line;
					s_cnt[e] <= stream_unit_count;
				end else if (adv) begin
					s_la[e] <= s_la[e] + LA_W'(1);
					s_cnt[e] <= s_cnt[e] - UC_W'(1);
					if (bnd || (s_lim[e] && s_cnt[e] <= UC_W'(1))) begin
						s_act[e] <= 1'b0;
					end
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////
	// Round-robin prefetch issue; the load arbiter gives it lowest priority
	logic [2:0] pick;
	logic pick_ok;
	always_comb begin
		logic [2:0] k;
		k = 3'h0;
		pick = rr_reg;
		pick_ok = 1'b0;
		for (int i = 1; i <= cbm_pkg::STREAMS; i++) begin
			k = rr_reg + 3'(i);
			if (!pick_ok && s_act[k]) begin
				pick_ok = 1'b1;
				pick = k;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pf_req <= 1'b0;
			pf_stream <= 3'h0;
			pf_line <= '0;
			rr_reg <= 3'h7;
		end else if (pf_req) begin
			if (pf_ready || (pf_drop && pf_drop_stream == pf_stream) || !s_act[pf_stream] ||
				(s_start && s_idx == pf_stream)) begin
				pf_req <= 1'b0;
			end
		end else if (pick_ok && !(s_start && s_idx == pick)) begin
			pf_req <= 1'b1;
			pf_stream <= pick;
			pf_line <= s_la[pick];
			rr_reg <= pick;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	scan_eight_a: assert property (
		$rose(ic_probe) |-> ic_probe [*8] ##1 (!ic_probe && ic_state == cbm_pkg::IC_KILL))
		else $error("probe pass not eight cycles");
	bcast_start_a: assert property (
		bc_out_valid |-> ic_probe && ic_line_idx == 3'h0 && ic_line == bc_out_line)
		else $error("broadcast without local scan");
	icbi_fault_a: assert property (
		acc && op_code == cbm_pkg::OP_ICBI && xl_fault |=> dsi_exc && !bc_out_valid)
		else $error("invalidate fault not reported");
	touch_silent_a: assert property (
		is_touch && data_translate_enable[op_thread] && xl_fault
		|=> !dsi_exc && !l2_touch_req && !tlb_reload)
		else $error("faulting touch not silent");
	tst_fill_a: assert property (
		$past(acc && op_code == cbm_pkg::OP_TOUCH_ST) && l2_touch_req |-> l2_touch_l1_fill)
		else $error("touch for store without L1 fill");
	zero_align_a: assert property (
		acc && op_code == cbm_pkg::OP_ZERO && !xl_fault && way_reg == 4'h0
		|=> align_int && !l1d_inval ##1 !(sq_req && sq_kind == cbm_pkg::SQ_ZERO))
		else $error("zero without ways not refused");
	zero_order_a: assert property (
		l1d_inval |=> sq_req && sq_kind == cbm_pkg::SQ_ZERO && $stable(out_line))
		else $error("zero not queued after invalidate");
	tlbie_kill_a: assert property (
		tlbie_event |=> s_act == 8'h0)
		else $error("streams survive TLB invalidate");
	stop_all_a: assert property (
		stop_all |=> ($past(op_thread) ? s_act[7:4] : s_act[3:0]) == 4'h0)
		else $error("thread streams survive stop");
	guard_nop_a: assert property (
		is_touch && fgl_reg |=> !l2_touch_req && !tlb_reload)
		else $error("touch acted under forced guard");
endmodule

// *** cbm_far_model.sv ***
`timescale 1ns/100ps
module cbm_far_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Scenario control
	input wire logic slow,
	input wire logic drop_cmd,
	input wire logic [7:0] hit_mask,
	// Instruction cache probe
	input wire logic ic_probe,
	input wire logic [2:0] ic_line_idx,
	output logic ic_probe_hit,
	// Prefetch port of the second level
	input wire logic pf_req,
	input wire logic [2:0] pf_stream,
	output logic pf_ready,
	output logic pf_drop,
	output logic [2:0] pf_drop_stream
);
	logic [1:0] wait_reg;
	logic tog_reg;
	////////////////////////////////////////////////////////////////
	// Outside a probe the answer toggles, so a stray sample never looks settled
	assign ic_probe_hit = ic_probe ? hit_mask[ic_line_idx] : tog_reg;
	always @(posedge clk_sys) begin
		if (!rstn) begin
			tog_reg <= 1'b0;
			wait_reg <= 2'h0;
			pf_ready <= 1'b0;
			pf_drop <= 1'b0;
			pf_drop_stream <= 3'h0;
		end else begin
			tog_reg <= ~tog_reg;
			// Slow mode stalls each request three cycles
			wait_reg <= (pf_req && !pf_ready) ? wait_reg + 2'h1 : 2'h0;
			pf_ready <= pf_req && !pf_ready && !drop_cmd && (!slow || wait_reg == 2'h3);
			// A demand load caught up with this prefetch
			pf_drop <= drop_cmd && pf_req && !pf_ready && !pf_drop;
			pf_drop_stream <= drop_cmd ? pf_stream : ~pf_drop_stream;
		end
	end
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
	localparam int RA_W = 42;
	localparam int UC_W = 10;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] reg_addr = 4'h0, touch_hint = 4'h0;
	logic [31:0] reg_wdata = 32'h0, rd_val, reg_rdata;
	logic reg_wr = 0, reg_rd = 0, op_valid = 0, op_thread = 0, op_indexed = 0, op_go = 0;
	logic op_page_4k = 0, l1d_hit = 0, tlbie_event = 0, bc_in_valid = 0, slow = 0, drop_cmd = 0;
	logic [2:0] op_code = 3'h0, ic_line_idx, pf_stream, pf_drop_stream;
	logic [1:0] op_stream_id = 2'h0, op_stop = 2'h0, dte = 2'h3, thr_en = 2'h3, sq_kind, kind;
	logic [UC_W-1:0] unit_cnt = 10'h1;
	logic [RA_W-1:0] op_ra = 42'h0_1234_5680;
	logic [RA_W-8:0] bc_in_line = 35'h0, bline, iline, out_line, ic_line, bc_out_line, pf_line;
	logic [5:0] xl = 6'h0;
	logic [5:0] cx [4] = '{6'h20, 6'h04, 6'h02, 6'h01};
	logic [7:0] hit_mask = 8'h25, seen, inv;
	logic op_busy, dsi_exc, align_int, tlb_reload, ic_probe, ic_inval, bc_out_valid, l1d_inval;
	logic l2_touch_req, l2_touch_l1_fill, sq_req, pf_req, pf_ready, pf_drop, ic_probe_hit;
	logic [2:0] tq_s [$];
	logic [RA_W-8:0] tq_l [$];
	int error_cnt = 0, total_checks = 0;
	always #10 clk_sys = ~clk_sys;
	cbm_top #(.RA_W(RA_W), .UC_W(UC_W)) cbm_top_i (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .op_valid, .op_code, .op_thread, .op_ra, .op_indexed, .touch_hint,
		.op_stream_id, .op_go, .op_stop, .stream_unit_count(unit_cnt), .op_page_4k, .l1d_hit,
		.op_busy, .xl_fault(xl[5]), .xl_tlb_miss(xl[4]), .xl_pte_found(xl[3]),
		.xl_prot_fail(xl[2]), .xl_cache_inhibit(xl[1]), .xl_guarded(xl[0]),
		.data_translate_enable(dte), .thread_enable(thr_en), .tlbie_event, .dsi_exc, .align_int,
		.tlb_reload, .out_line, .ic_probe, .ic_inval, .ic_line_idx, .ic_line, .ic_probe_hit,
		.bc_out_valid, .bc_out_line, .bc_in_valid, .bc_in_line, .l1d_inval, .l2_touch_req,
		.l2_touch_l1_fill, .sq_req, .sq_kind, .pf_req, .pf_stream, .pf_line, .pf_ready, .pf_drop,
		.pf_drop_stream);
	cbm_far_model cbm_far_model_i (.clk_sys, .rstn, .slow, .drop_cmd, .hit_mask, .ic_probe,
		.ic_line_idx, .ic_probe_hit, .pf_req, .pf_stream, .pf_ready, .pf_drop, .pf_drop_stream);
	////////////////////////////////////////////////////////////////
	// Mid-cycle sampling keeps queue clears at the edge free of races
	always @(negedge clk_sys) begin
		if (rstn && pf_req === 1'b1 && pf_ready === 1'b1) begin
			tq_s.push_back(pf_stream);
			tq_l.push_back(pf_line);
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic rd(input logic [3:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		rd_val = reg_rdata;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic stat(input logic [7:0] e);
		rd(cbm_pkg::REG_STAT);
		chk(rd_val, {24'h0, e});
	endtask
	// Code 7 stands for an invalidate arriving from a peer
	task automatic do_op(input logic [2:0] c, input logic [3:0] h, input int n);
		int k;
		for (k = 0; k < 40 && op_busy !== 1'b0; k++) @(posedge clk_sys);
		if (k == 40) begin
			error_cnt++;
			give_verdict();
		end
		seen = 8'h0;
		inv = 8'h0;
		if (c == 3'h7) bc_in_valid <= 1'b1;
		else op_valid <= 1'b1;
		op_code <= c;
		touch_hint <= h;
		@(posedge clk_sys);
		op_valid <= 1'b0;
		bc_in_valid <= 1'b0;
		repeat (n) begin
			@(posedge clk_sys);
			seen = seen | {dsi_exc, align_int, tlb_reload, l1d_inval, l2_touch_req,
				l2_touch_l1_fill & l2_touch_req, sq_req, bc_out_valid};
			if (sq_req) kind = sq_kind;
			if (bc_out_valid) bline = bc_out_line;
			if (ic_inval) begin
				inv[ic_line_idx] = 1'b1;
				iline = ic_line;
			end
		end
	endtask
	task automatic st(input logic t, input logic [1:0] id, input logic [3:0] h, input logic go,
		input logic [1:0] stp, input logic [RA_W-1:0] ra);
		op_thread <= t;
		op_stream_id <= id;
		op_go <= go;
		op_stop <= stp;
		op_ra <= ra;
		do_op(cbm_pkg::OP_TOUCH, h, 3);
	endtask
	task automatic takes(input int n);
		int k;
		for (k = 0; k < 300 && tq_s.size() < n; k++) @(posedge clk_sys);
		if (k == 300) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic wait_idle();
		int k;
		for (k = 0; k < 60; k++) begin
			rd(cbm_pkg::REG_STAT);
			if (rd_val[7:0] === 8'h0) break;
		end
		if (k == 60) begin
			error_cnt++;
			give_verdict();
		end
	endtask
	task automatic clr();
		tq_s.delete();
		tq_l.delete();
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		rd(cbm_pkg::REG_CTRL);
		chk(rd_val, 32'h0000_00f0);
		wr(cbm_pkg::REG_STAT, 32'h0000_00ff);
		stat(8'h0);
		rd(4'h8);
		chk(rd_val, 32'h0);
		wr(cbm_pkg::REG_CTRL, 32'h0000_00f7);
		rd(cbm_pkg::REG_CTRL);
		chk(rd_val, 32'h0000_00f7);
		wr(cbm_pkg::REG_CTRL, 32'h0000_00f0);
		$display("test registers done");
		for (int h = 0; h < 16; h++) begin
			if (h != 8 && h != 10) begin
				do_op(cbm_pkg::OP_TOUCH, 4'(h), 3);
				chk(seen, h < 8 ? 8'h0c : 8'h00);
			end
		end
		do_op(cbm_pkg::OP_TOUCH_ST, 4'hf, 3);
		chk(seen, 8'h0c);
		l1d_hit <= 1'b1;
		do_op(cbm_pkg::OP_TOUCH, 4'h0, 3);
		chk(seen, 8'h00);
		l1d_hit <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			xl <= cx[i];
			do_op(cbm_pkg::OP_TOUCH, 4'h0, 3);
			chk(seen, 8'h00);
		end
		xl <= 6'h18;
		do_op(cbm_pkg::OP_TOUCH, 4'h0, 3);
		chk(seen[5], 1'b1);
		chk(out_line, op_ra[RA_W-1:7]);
		xl <= 6'h10;
		do_op(cbm_pkg::OP_TOUCH, 4'h0, 3);
		chk(seen[5], 1'b0);
		xl <= 6'h0;
		op_indexed <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(cbm_pkg::REG_CTRL, 32'h0000_00f0 | (32'h1 << i));
			do_op(cbm_pkg::OP_TOUCH, 4'h0, 3);
			chk(seen, 8'h00);
		end
		wr(cbm_pkg::REG_CTRL, 32'h0000_00f2);
		op_indexed <= 1'b0;
		do_op(cbm_pkg::OP_TOUCH, 4'h0, 3);
		chk(seen, 8'h0c);
		wr(cbm_pkg::REG_CTRL, 32'h0000_00f0);
		$display("test touch done");
		do_op(cbm_pkg::OP_ICBI, 4'h0, 18);
		chk(seen, 8'h01);
		chk(inv, hit_mask);
		chk(bline, op_ra[RA_W-1:7]);
		hit_mask <= 8'h81;
		bc_in_line <= 35'h0_0abc_de01;
		do_op(3'h7, 4'h0, 18);
		chk(seen, 8'h00);
		chk(inv, 8'h81);
		chk(iline[31:0], 32'h0abc_de01);
		xl <= 6'h20;
		do_op(cbm_pkg::OP_ICBI, 4'h0, 18);
		chk(seen[7], 1'b1);
		xl <= 6'h0;
		$display("test invalidate done");
		l1d_hit <= 1'b1;
		do_op(cbm_pkg::OP_ZERO, 4'h0, 4);
		chk(seen, 8'h12);
		chk(kind, cbm_pkg::SQ_ZERO);
		l1d_hit <= 1'b0;
		xl <= 6'h02;
		do_op(cbm_pkg::OP_ZERO, 4'h0, 4);
		chk(seen, 8'h40);
		xl <= 6'h0;
		wr(cbm_pkg::REG_CTRL, 32'h0);
		do_op(cbm_pkg::OP_ZERO, 4'h0, 4);
		chk(seen, 8'h40);
		wr(cbm_pkg::REG_CTRL, 32'h0000_00f0);
		do_op(cbm_pkg::OP_FLUSH, 4'h0, 4);
		chk({seen, 6'h0, kind}, {8'h02, 6'h0, cbm_pkg::SQ_FLUSH});
		do_op(cbm_pkg::OP_STORE, 4'h0, 4);
		chk({seen, 6'h0, kind}, {8'h02, 6'h0, cbm_pkg::SQ_STORE});
		do_op(cbm_pkg::OP_VSTREAM, 4'h0, 4);
		chk(seen, 8'h00);
		$display("test block ops done");
		slow <= 1'b1;
		st(1'b0, 2'h1, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, 42'h100_0000);
		st(1'b1, 2'h2, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, 42'h200_0000);
		stat(8'h42);
		clr();
		takes(4);
		chk(tq_s[0] ^ tq_s[1], 3'h7);
		chk(tq_s[2], tq_s[0]);
		chk(tq_l[2], tq_l[0] + 35'h1);
		drop_cmd <= 1'b1;
		for (int k = 0; k < 20 && pf_drop !== 1'b1; k++) @(posedge clk_sys);
		drop_cmd <= 1'b0;
		chk(pf_drop, 1'b1);
		if (pf_drop !== 1'b1) give_verdict();
		stat(8'h42);
		slow <= 1'b0;
		st(1'b0, 2'h1, cbm_pkg::HINT_STREAM_EXT, 1'b0, cbm_pkg::STOP_ONE, 42'h0);
		stat(8'h40);
		st(1'b1, 2'h0, cbm_pkg::HINT_STREAM_EXT, 1'b0, cbm_pkg::STOP_ALL, 42'h0);
		stat(8'h00);
		st(1'b0, 2'h0, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, 42'h100_0000);
		clr();
		st(1'b0, 2'h0, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, 42'h300_0000);
		takes(1);
		chk(tq_l[0][31:0], 32'h0006_0000);
		stat(8'h01);
		dte <= 2'h2;
		@(posedge clk_sys);
		stat(8'h00);
		dte <= 2'h3;
		st(1'b0, 2'h0, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, 42'h100_0000);
		st(1'b1, 2'h3, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, 42'h200_0000);
		tlbie_event <= 1'b1;
		@(posedge clk_sys);
		tlbie_event <= 1'b0;
		stat(8'h00);
		st(1'b1, 2'h0, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, 42'h200_0000);
		thr_en <= 2'h1;
		@(posedge clk_sys);
		stat(8'h00);
		thr_en <= 2'h3;
		unit_cnt <= 10'h2;
		clr();
		st(1'b0, 2'h2, cbm_pkg::HINT_STREAM_EXT, 1'b1, 2'h0, 42'h100_0000);
		wait_idle();
		chk(32'(tq_s.size()), 32'h2);
		for (int p = 0; p < 2; p++) begin
			op_page_4k <= p[0];
			clr();
			st(1'b0, 2'h3, cbm_pkg::HINT_STREAM, 1'b1, 2'h0, p ? 42'h1_0f80 : 42'h1_ff80);
			wait_idle();
			chk(32'(tq_s.size()), 32'h1);
		end
		$display("test streams done");
		give_verdict();
	end
endmodule
